/* File: include/acr_cfg.svh */
// Register map, field positions, reset values and timing counts of the sequence controller
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Word indices; byte address is four times the index
`define ACR_IDX_CTRL2       6'd2
`define ACR_IDX_CTRL3       6'd3
`define ACR_IDX_CTRL5       6'd5
`define ACR_IDX_STAT0       6'd6
`define ACR_IDX_FLAGS       6'd7
`define ACR_IDX_CMPE        6'd8
`define ACR_IDX_IRQ_STAT    6'd9
`define ACR_IDX_IRQ_MASK    6'd10
`define ACR_IDX_RESULT      6'd16

// Control three fields
`define ACR_JUSTIFY_BIT     7
`define ACR_SEQ_HI          6
`define ACR_SEQ_LO          3
`define ACR_FIFO_BIT        2
`define ACR_HALT_HI         1
`define ACR_HALT_LO         0
`define ACR_CTRL3_RESET     8'h20
`define ACR_HALT_FINISH     2'h2
`define ACR_HALT_NOW        2'h3

// Control two and five fields
`define ACR_FAST_CLEAR_BIT  6
`define ACR_CMP_IRQ_BIT     0
`define ACR_SCAN_BIT        5

// Status zero fields above the counter
`define ACR_BUSY_BIT        4
`define ACR_HALTED_BIT      5

// Interrupt status bits
`define ACR_IRQ_SEQ_BIT     0
`define ACR_IRQ_CMP_BIT     1

// Conversion time
`define ACR_CLK_MHZ         20
`define ACR_CONV_TIME_NS    1000
`define ACR_CONV_CYCLES     ((`ACR_CONV_TIME_NS * `ACR_CLK_MHZ + 999) / 1000)

`endif

/* File: include/acr_pkg.sv */
// Types shared by the sequence controller
package acr_pkg;

    typedef enum logic [2:0] {
        ACR_IDLE = 3'b001,
        ACR_CONV = 3'b010,
        ACR_HALT = 3'b100
    } acr_state_t;

    typedef struct packed {
        acr_state_t        state;
        logic [7:0]        ctrl2;
        logic [7:0]        ctrl3;
        logic [7:0]        ctrl5;
        logic [15:0]       cmpe;
        logic [15:0]       flags;
        logic [1:0]        irq_stat;
        logic [1:0]        irq_mask;
        logic [3:0]        conv_counter;
        logic [4:0]        seq_count;
        logic [15:0]       timer;
        logic [15:0][15:0] results;
        logic              ack;
        logic [31:0]       rdata;
    } acr_regs_t;

endpackage : acr_pkg

/* File: src/acr_seq_ctrl.sv */
// Sequence controller with result slots, complete flags and breakpoint halt
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"

module acr_seq_ctrl #(
    parameter int RES_BITS    = 12,
    parameter int CONV_CYCLES = `ACR_CONV_CYCLES
) (
    input  wire logic                clock_in,
    input  wire logic                rst_in,
    input  wire logic [7:0]          avs_address_in,
    input  wire logic                avs_read_in,
    input  wire logic                avs_write_in,
    input  wire logic [31:0]         avs_writedata_in,
    input  wire logic [3:0]          avs_byteenable_in,
    output logic [31:0]              avs_readdata_out,
    output logic                     avs_waitrequest_out,
    input  wire logic [RES_BITS-1:0] analog_code_in,
    input  wire logic                breakpoint_in,
    output logic                     irq_out
);
    import acr_pkg::*;

    // --------------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------------
    if (RES_BITS < 1 || RES_BITS > 16) begin : g_bad_res
        $error("RES_BITS must lie in 1..16");
    end
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
        $error("CONV_CYCLES must lie in 1..65535");
    end

    localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Length field to conversion count, zero meaning sixteen
    function automatic logic [4:0] seq_len(input logic [7:0] c3);
        logic [3:0] f;
        f = c3[`ACR_SEQ_HI:`ACR_SEQ_LO];
        return (f == 4'h0) ? 5'h10 : {1'b0, f};
    endfunction : seq_len

    // Justify a raw code into a 16-bit result word
    function automatic logic [15:0] justify(input logic [RES_BITS-1:0] code,
                                            input logic                right);
        logic [15:0] w;
        w = 16'(code);
        return right ? w : 16'(w << (16 - RES_BITS));
    endfunction : justify

    acr_regs_t r_reg;
    acr_regs_t r_next;

    // --------------------------------------------------------------------
    // Decoded views
    // --------------------------------------------------------------------
    logic        req;
    logic        take;
    logic [5:0]  widx;
    logic        fifo_on;
    logic [1:0]  halt_sel;
    logic        hold_now;
    logic        conv_done;
    logic [15:0] cmp_active;
    logic [31:0] rd_val;

    // Bus timing: one wait cycle, request acted on when waitrequest is low
    assign req      = avs_read_in | avs_write_in;
    assign take     = req & r_reg.ack;
    assign widx     = avs_address_in[7:2];
    assign fifo_on  = r_reg.ctrl3[`ACR_FIFO_BIT];
    assign halt_sel = r_reg.ctrl3[`ACR_HALT_HI:`ACR_HALT_LO];
    // Immediate freeze stops the conversion timer mid-way
    assign hold_now  = breakpoint_in && (halt_sel == `ACR_HALT_NOW);
    assign conv_done = (r_reg.state == ACR_CONV) && !hold_now && (r_reg.timer == CONV_LAST);
    // FIFO mode masks every per-conversion compare enable
    assign cmp_active = fifo_on ? 16'h0000 : r_reg.cmpe;

    assign avs_waitrequest_out = req & ~r_reg.ack;
    assign avs_readdata_out    = r_reg.rdata;
    assign irq_out             = |(r_reg.irq_stat & r_reg.irq_mask);

    // --------------------------------------------------------------------
    // Read mux
    // --------------------------------------------------------------------
    // Address decode for reads; unmapped words read as zero
    always_comb begin
        rd_val = 32'h0;
        if (widx == `ACR_IDX_CTRL2) begin
            rd_val = {24'h0, r_reg.ctrl2};
        end else if (widx == `ACR_IDX_CTRL3) begin
            rd_val = {24'h0, r_reg.ctrl3};
        end else if (widx == `ACR_IDX_CTRL5) begin
            rd_val = {24'h0, r_reg.ctrl5};
        end else if (widx == `ACR_IDX_STAT0) begin
            rd_val = {26'h0, r_reg.state == ACR_HALT, r_reg.state != ACR_IDLE,
                      r_reg.conv_counter};
        end else if (widx == `ACR_IDX_FLAGS) begin
            rd_val = {16'h0, r_reg.flags};
        end else if (widx == `ACR_IDX_CMPE) begin
            rd_val = {16'h0, r_reg.cmpe};
        end else if (widx == `ACR_IDX_IRQ_STAT) begin
            rd_val = {30'h0, r_reg.irq_stat};
        end else if (widx == `ACR_IDX_IRQ_MASK) begin
            rd_val = {30'h0, r_reg.irq_mask};
        end else if (widx >= `ACR_IDX_RESULT) begin
            rd_val = {16'h0, r_reg.results[widx[3:0]]};
        end
    end

    // --------------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------------
    always_comb begin
        logic [31:0] m;
        logic [15:0] clr;
        logic [15:0] set;
        logic        seq_end;
        logic        cmp_evt;
        logic        seq_evt;
        logic        abort;
        logic        start;
        m       = 32'h0;
        clr     = 16'h0;
        set     = 16'h0;
        seq_end = 1'b0;
        cmp_evt = 1'b0;
        seq_evt = 1'b0;
        abort   = 1'b0;
        start   = 1'b0;
        r_next  = r_reg;

        // Bus handshake and read data capture
        r_next.ack = req & ~r_reg.ack;
        if (avs_read_in && !r_reg.ack) begin
            r_next.rdata = rd_val;
        end

        // Register writes and read side effects
        if (take && avs_write_in) begin
            if (widx == `ACR_IDX_CTRL2) begin
                m = be_merge({24'h0, r_reg.ctrl2}, avs_writedata_in, avs_byteenable_in);
                r_next.ctrl2 = m[7:0];
            end else if (widx == `ACR_IDX_CTRL3) begin
                m = be_merge({24'h0, r_reg.ctrl3}, avs_writedata_in, avs_byteenable_in);
                r_next.ctrl3 = m[7:0];
                abort = 1'b1;
            end else if (widx == `ACR_IDX_CTRL5) begin
                m = be_merge({24'h0, r_reg.ctrl5}, avs_writedata_in, avs_byteenable_in);
                r_next.ctrl5 = m[7:0];
                start = 1'b1;
            end else if (widx == `ACR_IDX_FLAGS) begin
                m = be_merge(32'h0, avs_writedata_in, avs_byteenable_in);
                clr = m[15:0];
            end else if (widx == `ACR_IDX_CMPE) begin
                m = be_merge({16'h0, r_reg.cmpe}, avs_writedata_in, avs_byteenable_in);
                r_next.cmpe = m[15:0];
            end else if (widx == `ACR_IDX_IRQ_STAT) begin
                m = be_merge(32'h0, avs_writedata_in, avs_byteenable_in);
                r_next.irq_stat = r_reg.irq_stat & ~m[1:0];
            end else if (widx == `ACR_IDX_IRQ_MASK) begin
                m = be_merge({30'h0, r_reg.irq_mask}, avs_writedata_in, avs_byteenable_in);
                r_next.irq_mask = m[1:0];
            end else if (widx >= `ACR_IDX_RESULT) begin
                // Fast clear on a compare-enabled slot clears by write
                if (r_reg.ctrl2[`ACR_FAST_CLEAR_BIT] && cmp_active[widx[3:0]]) begin
                    clr[widx[3:0]] = 1'b1;
                end
            end
        end
        if (take && avs_read_in && widx >= `ACR_IDX_RESULT) begin
            // Fast clear on a compare-disabled slot clears by read
            if (r_reg.ctrl2[`ACR_FAST_CLEAR_BIT] && !cmp_active[widx[3:0]]) begin
                clr[widx[3:0]] = 1'b1;
            end
        end

        // Conversion sequencing
        case (r_reg.state)
            ACR_IDLE: begin
                r_next.timer = 16'h0;
            end
            ACR_CONV: begin
                if (!hold_now) begin
                    r_next.timer = r_reg.timer + 16'h1;
                end
                if (conv_done) begin
                    r_next.timer = 16'h0;
                    r_next.results[r_reg.conv_counter] =
                        justify(analog_code_in, r_reg.ctrl3[`ACR_JUSTIFY_BIT]);
                    set[r_reg.conv_counter] = 1'b1;
                    cmp_evt = cmp_active[r_reg.conv_counter]
                              && r_reg.ctrl2[`ACR_CMP_IRQ_BIT] && !fifo_on;
                    // Four-bit counter wraps from last slot to first
                    r_next.conv_counter = r_reg.conv_counter + 4'h1;
                    r_next.seq_count = r_reg.seq_count + 5'h1;
                    seq_end = (r_reg.seq_count + 5'h1) == seq_len(r_reg.ctrl3);
                    if (seq_end) begin
                        seq_evt = 1'b1;
                        r_next.seq_count = 5'h0;
                        if (!fifo_on) begin
                            r_next.conv_counter = 4'h0;
                        end
                        if (!r_reg.ctrl5[`ACR_SCAN_BIT]) begin
                            r_next.state = ACR_IDLE;
                        end
                    end
                    if (r_next.state == ACR_CONV && breakpoint_in
                            && halt_sel == `ACR_HALT_FINISH) begin
                        r_next.state = ACR_HALT;
                    end
                end
            end
            ACR_HALT: begin
                // Resume once the breakpoint is gone or the mode no longer halts
                if (!breakpoint_in || halt_sel != `ACR_HALT_FINISH) begin
                    r_next.state = ACR_CONV;
                end
            end
            default: begin
                r_next.state = ACR_IDLE;
            end
        endcase

        // Abort or start wins over sequencing and clears the counter
        if (abort || start) begin
            r_next.conv_counter = 4'h0;
            r_next.seq_count    = 5'h0;
            r_next.timer        = 16'h0;
            r_next.state        = start ? ACR_CONV : ACR_IDLE;
        end

        // Set beats clear for flags and interrupt status
        r_next.flags = (r_reg.flags & ~clr) | set;
        if (seq_evt) begin
            r_next.irq_stat[`ACR_IRQ_SEQ_BIT] = 1'b1;
        end
        if (cmp_evt) begin
            r_next.irq_stat[`ACR_IRQ_CMP_BIT] = 1'b1;
        end
    end

    // --------------------------------------------------------------------
    // State register
    // --------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            r_reg       <= '0;
            r_reg.state <= ACR_IDLE;
            r_reg.ctrl3 <= `ACR_CTRL3_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    a_ctrl3_write_abort: assert property (@(posedge clock_in) disable iff (rst_in)
        (take && avs_write_in && widx == `ACR_IDX_CTRL3) |=>
            (r_reg.state == ACR_IDLE && r_reg.conv_counter == 4'h0))
        else $error("control three write did not abort");

    a_reset_len_four: assert property (@(posedge clock_in)
        $fell(rst_in) |-> r_reg.ctrl3 == `ACR_CTRL3_RESET)
        else $error("length field not four after reset");

    a_slot_follows_seq: assert property (@(posedge clock_in) disable iff (rst_in)
        (r_reg.state == ACR_CONV && !fifo_on) |-> r_reg.conv_counter == r_reg.seq_count[3:0])
        else $error("non fifo slot differs from sequence index");

    a_fifo_keeps_count: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && fifo_on && !take) |=> r_reg.conv_counter == $past(r_reg.conv_counter) + 4'h1)
        else $error("fifo counter did not advance");

    a_seq_len_stop: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && !take && !r_reg.ctrl5[`ACR_SCAN_BIT]
            && r_reg.seq_count + 5'h1 == seq_len(r_reg.ctrl3)) |=> r_reg.state == ACR_IDLE)
        else $error("single sequence did not stop at length");

    a_start_clears_cc: assert property (@(posedge clock_in) disable iff (rst_in)
        (take && avs_write_in && widx == `ACR_IDX_CTRL5) |=>
            (r_reg.conv_counter == 4'h0 && r_reg.state == ACR_CONV))
        else $error("start did not clear counter");

    a_flag_on_write: assert property (@(posedge clock_in) disable iff (rst_in)
        conv_done |=> r_reg.flags[$past(r_reg.conv_counter)])
        else $error("complete flag not set");

    a_fifo_no_cmp: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && fifo_on && !r_reg.irq_stat[`ACR_IRQ_CMP_BIT])
            |=> !r_reg.irq_stat[`ACR_IRQ_CMP_BIT])
        else $error("compare fired in fifo mode");

    a_freeze_now_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (r_reg.state == ACR_CONV && hold_now && !take) |=> $stable(r_reg.timer))
        else $error("timer ran during immediate freeze");

    a_halt_resume: assert property (@(posedge clock_in) disable iff (rst_in)
        (r_reg.state == ACR_HALT && !breakpoint_in && !take) |=> r_reg.state == ACR_CONV)
        else $error("halt did not resume");

    a_right_justify: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && r_reg.ctrl3[`ACR_JUSTIFY_BIT])
            |=> r_reg.results[$past(r_reg.conv_counter)] == 16'($past(analog_code_in)))
        else $error("right justified result differs from the code");

    a_left_justify: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && !r_reg.ctrl3[`ACR_JUSTIFY_BIT])
            |=> (r_reg.results[$past(r_reg.conv_counter)] >> (16 - RES_BITS))
                == 16'($past(analog_code_in)))
        else $error("left justified result differs from the code");

    a_fifo_slot_wrap: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && fifo_on && !take && r_reg.conv_counter == 4'hf)
            |=> r_reg.conv_counter == 4'h0)
        else $error("fifo counter did not wrap to the first slot");

    a_finish_then_halt: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && !take && breakpoint_in && halt_sel == `ACR_HALT_FINISH)
            |=> r_reg.state != ACR_CONV)
        else $error("finish mode went on converting");

    a_fast_read_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (take && avs_read_in && widx >= `ACR_IDX_RESULT && r_reg.ctrl2[`ACR_FAST_CLEAR_BIT]
            && !cmp_active[widx[3:0]] && !conv_done)
            |=> !r_reg.flags[$past(widx[3:0])])
        else $error("fast clear read left the flag set");

    a_cmp_event_irq: assert property (@(posedge clock_in) disable iff (rst_in)
        (conv_done && r_reg.ctrl2[`ACR_CMP_IRQ_BIT] && cmp_active[r_reg.conv_counter])
            |=> r_reg.irq_stat[`ACR_IRQ_CMP_BIT])
        else $error("compare event did not raise its status bit");

endmodule : acr_seq_ctrl

`default_nettype wire

/* File: test/acr_far_side.sv */
// Far-side model: debug breakpoint logic and analog source of the controller
`timescale 1ns/1ps
`default_nettype none

module acr_far_side (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] level_in,
    input  wire logic        halt_req_in,
    output logic [11:0]      analog_code_out,
    output logic             breakpoint_out
);
    // Registered so both lines move just after an edge, as debug logic does
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            analog_code_out <= 12'h000;
            breakpoint_out  <= 1'b0;
        end else begin
            analog_code_out <= level_in;
            breakpoint_out  <= halt_req_in;
        end
    end
endmodule : acr_far_side
`default_nettype wire

/* File: test/adc_sequence_result_config_tb.sv */
// Self-checking bench of the sequence controller
`timescale 1ns/1ps
`default_nettype none

module adc_sequence_result_config_tb;
    typedef struct {
        logic [5:0]  idx;
        logic [31:0] wd;
        logic [31:0] exp;
    } acr_row_t;

    logic        clock_in, rst_in, rd_in, wr_in, wait_rq, irq, bp, halt_req;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rd;
    logic [11:0] level, code;
    logic [31:0] halt_exp [4];
    logic [31:0] halt_stat [4];
    acr_row_t    rows [6];
    int          n_fail, n_checks, cycles;

    // ------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // Short conversions keep the run brief; polling still sees every count
    acr_seq_ctrl #(.RES_BITS(12), .CONV_CYCLES(8)) i_acr_seq_ctrl (
        .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(addr),
        .avs_read_in(rd_in), .avs_write_in(wr_in), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_rq), .analog_code_in(code),
        .breakpoint_in(bp), .irq_out(irq));

    acr_far_side i_acr_far_side (
        .clock_in(clock_in), .rst_in(rst_in), .level_in(level),
        .halt_req_in(halt_req), .analog_code_out(code), .breakpoint_out(bp));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Irq is sampled mid-cycle so the last write has landed
    task automatic chk_bit(input logic exp);
        @(negedge clock_in);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : chk_bit

    // Avalon access: hold everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        @(posedge clock_in);
        addr  <= {idx, 2'b00};
        wdata <= wd;
        wr_in <= w;
        rd_in <= ~w;
        do begin
            @(posedge clock_in);
        end while (wait_rq !== 1'b0);
        rd = rdata;
        wr_in <= 1'b0;
        rd_in <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // Poll busy until the sequence ends, bounded
    task automatic wait_idle();
        for (int i = 0; i < 100; i++) begin
            bus(1'b0, 6'd6, 32'h0);
            if (rd[4] === 1'b0) break;
        end
        chk({31'h0, rd[4]}, 32'h0);
    endtask : wait_idle

    // Poll the counter field until it shows v, then compare it
    task automatic wait_cc(input logic [3:0] v);
        for (int i = 0; i < 200; i++) begin
            bus(1'b0, 6'd6, 32'h0);
            if (rd[3:0] === v) break;
        end
        chk({28'h0, rd[3:0]}, {28'h0, v});
    endtask : wait_cc

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rd_in, wr_in, halt_req, addr, wdata, level} = '0;
        rst_in = 1'b1;
        rows = '{'{6'd3, 32'hff, 32'hff}, '{6'd3, 32'h00, 32'h00},
                 '{6'd2, 32'h41, 32'h41}, '{6'd8, 32'hffff, 32'hffff},
                 '{6'd4, 32'h55, 32'h0},  '{6'd6, 32'hff, 32'h0}};
        halt_exp = '{32'h3, 32'h3, 32'h1, 32'h0};
        halt_stat = '{32'h0, 32'h0, 32'h31, 32'h10};
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        rdchk(6'd3, 32'h20);
        chk_bit(1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wd);
            rdchk(rows[i].idx, rows[i].exp);
        end
        bus(1'b1, 6'd2, 32'h0);
        bus(1'b1, 6'd8, 32'h0);
        $display("test register rows done");
        // Right justify, length 2, fixed slots
        level <= 12'h123;
        bus(1'b1, 6'd3, 32'h90);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        rdchk(6'd16, 32'h0123);
        rdchk(6'd17, 32'h0123);
        rdchk(6'd18, 32'h0);
        rdchk(6'd7, 32'h3);
        rdchk(6'd6, 32'h0);
        bus(1'b1, 6'd3, 32'h08);
        bus(1'b1, 6'd7, 32'hffff);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        rdchk(6'd16, 32'h1230);
        // Length field zero runs sixteen conversions into every slot
        bus(1'b1, 6'd7, 32'hffff);
        bus(1'b1, 6'd3, 32'h80);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        rdchk(6'd7, 32'hffff);
        rdchk(6'd31, 32'h0123);
        $display("test justify and slots done");
        // FIFO scanning, length 3: counter runs past the length and wraps
        bus(1'b1, 6'd3, 32'h1c);
        bus(1'b1, 6'd5, 32'h20);
        wait_cc(4'd4);
        wait_cc(4'd1);
        bus(1'b1, 6'd3, 32'h1c);
        rdchk(6'd6, 32'h0);
        $display("test fifo done");
        // Compare interrupt, then the same with FIFO mode
        bus(1'b1, 6'd7, 32'hffff);
        bus(1'b1, 6'd9, 32'h3);
        bus(1'b1, 6'd2, 32'h1);
        bus(1'b1, 6'd8, 32'h1);
        bus(1'b1, 6'd10, 32'h2);
        bus(1'b1, 6'd3, 32'h08);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        rdchk(6'd9, 32'h3);
        chk_bit(1'b1);
        bus(1'b1, 6'd9, 32'h3);
        chk_bit(1'b0);
        bus(1'b1, 6'd3, 32'h0c);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        rdchk(6'd9, 32'h1);
        chk_bit(1'b0);
        bus(1'b1, 6'd10, 32'h1);
        chk_bit(1'b1);
        $display("test compare irq done");
        // Fast clear by read, then plain write-one clear
        bus(1'b1, 6'd9, 32'h3);
        bus(1'b1, 6'd10, 32'h0);
        bus(1'b1, 6'd8, 32'h0);
        bus(1'b1, 6'd2, 32'h40);
        bus(1'b1, 6'd7, 32'hffff);
        bus(1'b1, 6'd3, 32'h08);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        bus(1'b0, 6'd16, 32'h0);
        rdchk(6'd7, 32'h0);
        bus(1'b1, 6'd2, 32'h0);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        bus(1'b0, 6'd16, 32'h0);
        rdchk(6'd7, 32'h1);
        bus(1'b1, 6'd7, 32'h1);
        rdchk(6'd7, 32'h0);
        // Compare-enabled slot: a read keeps the flag, a write clears it
        bus(1'b1, 6'd8, 32'h1);
        bus(1'b1, 6'd2, 32'h40);
        bus(1'b1, 6'd5, 32'h0);
        wait_idle();
        rdchk(6'd16, 32'h1230);
        rdchk(6'd7, 32'h1);
        bus(1'b1, 6'd16, 32'h0);
        rdchk(6'd7, 32'h0);
        $display("test flag clear done");
        // Every halt code with the breakpoint up from the start, length 2
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 6'd7, 32'hffff);
            bus(1'b1, 6'd3, 32'h10 | m);
            halt_req <= 1'b1;
            bus(1'b1, 6'd5, 32'h0);
            repeat (40) @(posedge clock_in);
            rdchk(6'd7, halt_exp[m]);
            rdchk(6'd6, halt_stat[m]);
            halt_req <= 1'b0;
            repeat (40) @(posedge clock_in);
            rdchk(6'd7, 32'h3);
        end
        $display("test halt modes done");
        // Reset in the middle of a scan brings every register back to its reset value
        bus(1'b1, 6'd3, 32'h1c);
        bus(1'b1, 6'd5, 32'h20);
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        rdchk(6'd3, 32'h20);
        rdchk(6'd6, 32'h0);
        rdchk(6'd7, 32'h0);
        chk_bit(1'b0);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : adc_sequence_result_config_tb
`default_nettype wire
